// [logic/wom_pkg.sv]
// constants and carriers for the watchdog operation-mode block
package wom_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [15:0] MODE_IDX = 16'hFF48;
   localparam logic [15:0] KEY_IDX = 16'hFF49;
   localparam logic [15:0] STAT_IDX = 16'hFF4A;
   localparam int ADDR_W = 18;
   localparam logic [17:0] MODE_ADDR = {MODE_IDX, 2'b00};
   localparam logic [17:0] KEY_ADDR = {KEY_IDX, 2'b00};
   localparam logic [17:0] STAT_ADDR = {STAT_IDX, 2'b00};
   // reset values and key
   localparam logic [7:0] MODE_RST = 8'h67;
   localparam logic [7:0] KEY_READ = 8'h9A;
   localparam logic [7:0] KEY_RESTART = 8'hAC;
   // mode register fields
   localparam int CSEL_HI_POS = 4;
   localparam int CSEL_LO_POS = 3;
   localparam int PSEL_HI_POS = 2;
   localparam logic [1:0] CSEL_SLOW = 2'b00;
   // byte-lane 0 strobe
   localparam logic [3:0] BYTE_STRB = 4'h1;
   // overflow exponents for period select zero
   localparam int SLOW_EXP_BASE = 11;
   localparam int SYS_EXP_BASE = 13;
   localparam int CNT_W = 21;
   // stop interval after stop release
   localparam int CLK_MHZ = 100;
   localparam int STOP_GAP_US = 34;
   localparam int STOP_GAP_MIN_US = 17;
   localparam int STOP_GAP_MAX_US = 67;
   localparam int STOP_GAP_CYC = STOP_GAP_US * CLK_MHZ;
   localparam int GAP_W = 13;
   // sync bit positions
   localparam int SY_SLOW = 0;
   localparam int SY_SYS = 1;
   localparam int SY_STABLE = 2;
   localparam int SY_STRAP = 3;
   localparam int SY_W = 4;

   typedef enum logic [3:0] {
      ST_RUN = 4'b0001,
      ST_HOLD = 4'b0010,
      ST_SETTLE = 4'b0100,
      ST_GAP = 4'b1000
   } wom_state_t;

   typedef struct packed {
      logic [7:0] mode;
      logic written;
      logic exempt;
      logic fixed;
   } wom_cfg_t;
endpackage : wom_pkg

// [logic/wom_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module wom_sync #(
   parameter int WIDTH = 4
) (
   // clock
   input wire logic clk,
   // async in, synced out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;

   initial begin
      if (WIDTH < 1) $error("wom_sync width must be positive");
   end

   always_ff @(posedge clk) begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
   end
endmodule : wom_sync

// [logic/wom_counter.sv]
// watchdog counter with period decode and overflow pulse
`timescale 1ns/1ps
module wom_counter #(
   parameter int CNT_W = wom_pkg::CNT_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic clr,
   input wire logic inc,
   input wire logic use_sys,
   input wire logic [2:0] period_sel,
   // status
   output logic [CNT_W-1:0] count_ff,
   output logic ovf_ff
);
   logic [CNT_W-1:0] last;

   initial begin
      if (CNT_W < wom_pkg::SYS_EXP_BASE + 8) $error("counter too narrow");
   end

   // terminal count for the selected clock and period
   function automatic logic [CNT_W-1:0] term_cnt(input logic sys,
                                                input logic [2:0] ps);
      int e;
      e = (sys ? wom_pkg::SYS_EXP_BASE : wom_pkg::SLOW_EXP_BASE) + int'(ps);
      return CNT_W'((64'(1) << e) - 64'(1));
   endfunction : term_cnt

   assign last = term_cnt(use_sys, period_sel);

   always_ff @(posedge clk) begin
      if (rst || clr) begin
         count_ff <= '0;
      end else if (inc) begin
         count_ff <= (count_ff >= last) ? '0 : count_ff + CNT_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst || clr) begin
         ovf_ff <= 1'b0;
      end else begin
         ovf_ff <= inc && (count_ff >= last);
      end
   end
endmodule : wom_counter

// [logic/wom_top.sv]
// watchdog with fixed and selectable clock modes, apb registers
// What this block does
// - fixed mode always counts on the low-speed clock
// - fixed mode counts from reset release with longest period
// - fixed mode cannot be stopped by any request
// - fixed mode ignores clock-select bits, keeps low-speed clock
// - first write of the mode register clears the counter
// - three low mode bits pick the overflow period
// - restart key write clears counter and resumes counting
// - fixed mode counts through stop; overflow raises internal reset
// - selectable mode offers low-speed clock, system clock, or stopped
// - first write stopping watchdog exempts later faults from reset
// - selectable mode freezes in halt/stop, resumes keeping count
// - after stop release hold idle about 34 us then resume
// - system clock with crystal: settle first, then stop interval
// - selectable mode freezes count in stop on either clock
// - selectable mode freezes count in halt on either clock
// - clock select: 00 slow, 01 system, 1x stopped
// - one mode write allowed; second write resets unless stopped
// - any non-key value to the enable register resets unless stopped
// - enable register always reads a fixed value
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module wom_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [wom_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata_ff,
   output logic pready_ff,
   output logic pslverr_ff,
   // oscillators and strap, from pins
   input wire logic slow_osc_clk,
   input wire logic sys_osc_clk,
   input wire logic osc_settled,
   input wire logic osc_fixed_strap,
   // cpu power state, same clock
   input wire logic halt_mode,
   input wire logic stop_mode,
   input wire logic crystal_in_use,
   // internal reset request
   output logic wdt_reset_ff
);
   ////////////////////////////////////////////////////////////////////////
   // declarations
   wom_pkg::wom_cfg_t cfg_ff;
   wom_pkg::wom_state_t state_ff;
   wom_pkg::wom_state_t nxt_state;
   logic [wom_pkg::SY_W-1:0] sy;
   logic slow_prev_ff;
   logic sys_prev_ff;
   logic stop_prev_ff;
   logic from_stop_ff;
   logic [wom_pkg::GAP_W-1:0] gap_ff;
   logic [wom_pkg::CNT_W-1:0] count;
   logic ovf;
   logic slow_rise;
   logic sys_rise;
   logic acc;
   logic wr_mode;
   logic wr_key;
   logic mapped;
   logic byte_wr;
   logic key_fault;
   logic mode_fault;
   logic [1:0] csel;
   logic stopped;
   logic use_sys;
   logic tick;
   logic cnt_clr;
   logic [7:0] nxt_mode;
   logic gap_done;
   logic hit_mode;
   logic hit_key;
   logic hit_stat;
   localparam int GAP_W = wom_pkg::GAP_W;
   localparam int GAP_MIN = wom_pkg::STOP_GAP_MIN_US * wom_pkg::CLK_MHZ;
   localparam int GAP_MAX = wom_pkg::STOP_GAP_MAX_US * wom_pkg::CLK_MHZ;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detect
   wom_sync #(
      .WIDTH(wom_pkg::SY_W)
   ) u_sync (
      .clk(clk),
      .async_in({osc_fixed_strap, osc_settled, sys_osc_clk, slow_osc_clk}),
      .sync_out(sy)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         slow_prev_ff <= 1'b0;
         sys_prev_ff <= 1'b0;
      end else begin
         slow_prev_ff <= sy[wom_pkg::SY_SLOW];
         sys_prev_ff <= sy[wom_pkg::SY_SYS];
      end
   end

   assign slow_rise = sy[wom_pkg::SY_SLOW] && !slow_prev_ff;
   assign sys_rise = sy[wom_pkg::SY_SYS] && !sys_prev_ff;

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   // byte-address match for one register
   function automatic logic reg_hit(input logic [wom_pkg::ADDR_W-1:0] a,
                                    input logic [wom_pkg::ADDR_W-1:0] r);
      return a == r;
   endfunction : reg_hit

   assign hit_mode = reg_hit(paddr, wom_pkg::MODE_ADDR);
   assign hit_key = reg_hit(paddr, wom_pkg::KEY_ADDR);
   assign hit_stat = reg_hit(paddr, wom_pkg::STAT_ADDR);
   assign acc = psel && penable && pready_ff;
   assign mapped = hit_mode || hit_key || hit_stat;
   assign wr_mode = acc && pwrite && hit_mode;
   assign wr_key = acc && pwrite && hit_key;
   assign byte_wr = pstrb[0];

   always_ff @(posedge clk) begin
      if (rst) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= psel && penable && !pready_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pslverr_ff <= 1'b0;
      end else begin
         pslverr_ff <= psel && penable && !pready_ff && !mapped;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel && penable && !pready_ff && !pwrite) begin
         if (hit_mode) begin
            prdata_ff <= {24'h00_0000, cfg_ff.mode};
         end else if (hit_key) begin
            prdata_ff <= {24'h00_0000, wom_pkg::KEY_READ};
         end else if (hit_stat) begin
            prdata_ff <= {3'b000, cfg_ff.fixed, state_ff, 3'b000,
                          count};
         end else begin
            prdata_ff <= 32'h0000_0000;
         end
      end else begin
         prdata_ff <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode register, write-once tracking, strap latch
   always_comb begin
      nxt_mode = pwdata[7:0];
      if (cfg_ff.fixed) begin
         nxt_mode[wom_pkg::CSEL_HI_POS:wom_pkg::CSEL_LO_POS] =
            wom_pkg::CSEL_SLOW;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_ff.fixed <= sy[wom_pkg::SY_STRAP];
         cfg_ff.mode <= wom_pkg::MODE_RST;
         cfg_ff.written <= 1'b0;
         cfg_ff.exempt <= 1'b0;
      end else if (wr_mode && byte_wr && !cfg_ff.written) begin
         cfg_ff.mode <= nxt_mode;
         cfg_ff.written <= 1'b1;
         cfg_ff.exempt <= nxt_mode[wom_pkg::CSEL_HI_POS];
      end
   end

   assign csel = cfg_ff.mode[wom_pkg::CSEL_HI_POS:wom_pkg::CSEL_LO_POS];
   assign stopped = !cfg_ff.fixed && csel[1];
   assign use_sys = !cfg_ff.fixed && (csel == 2'b01);

   ////////////////////////////////////////////////////////////////////////
   // internal reset sources
   assign mode_fault = wr_mode && cfg_ff.written && !cfg_ff.exempt;
   assign key_fault = wr_key && !cfg_ff.exempt &&
                      (!byte_wr || pwdata[7:0] != wom_pkg::KEY_RESTART);

   always_ff @(posedge clk) begin
      if (rst) begin
         wdt_reset_ff <= 1'b0;
      end else begin
         wdt_reset_ff <= ovf || mode_fault || key_fault;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // halt / stop sequencing
   always_ff @(posedge clk) begin
      if (rst) begin
         stop_prev_ff <= 1'b0;
      end else begin
         stop_prev_ff <= stop_mode;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         from_stop_ff <= 1'b0;
      end else if (state_ff == wom_pkg::ST_HOLD && stop_mode) begin
         from_stop_ff <= 1'b1;
      end else if (state_ff == wom_pkg::ST_RUN) begin
         from_stop_ff <= 1'b0;
      end
   end

   assign gap_done = (gap_ff == GAP_W'(wom_pkg::STOP_GAP_CYC - 1));

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         wom_pkg::ST_RUN: begin
            if (!cfg_ff.fixed && (halt_mode || stop_mode)) begin
               nxt_state = wom_pkg::ST_HOLD;
            end
         end
         wom_pkg::ST_HOLD: begin
            if (!halt_mode && !stop_mode) begin
               if (!from_stop_ff && !stop_prev_ff) begin
                  nxt_state = wom_pkg::ST_RUN;
               end else if (use_sys && crystal_in_use) begin
                  nxt_state = wom_pkg::ST_SETTLE;
               end else begin
                  nxt_state = wom_pkg::ST_GAP;
               end
            end
         end
         wom_pkg::ST_SETTLE: begin
            if (sy[wom_pkg::SY_STABLE]) begin
               nxt_state = wom_pkg::ST_GAP;
            end
         end
         wom_pkg::ST_GAP: begin
            if (gap_done) begin
               nxt_state = wom_pkg::ST_RUN;
            end
         end
         default: nxt_state = wom_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= wom_pkg::ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || state_ff != wom_pkg::ST_GAP) begin
         gap_ff <= '0;
      end else begin
         gap_ff <= gap_ff + GAP_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counter
   assign tick = (state_ff == wom_pkg::ST_RUN) && !stopped &&
                 (use_sys ? sys_rise : slow_rise);
   assign cnt_clr = (wr_mode && byte_wr && !cfg_ff.written) ||
                    (wr_key && byte_wr &&
                     pwdata[7:0] == wom_pkg::KEY_RESTART);

   wom_counter #(
      .CNT_W(wom_pkg::CNT_W)
   ) u_cnt (
      .clk(clk),
      .rst(rst),
      .clr(cnt_clr),
      .inc(tick),
      .use_sys(use_sys),
      .period_sel(cfg_ff.mode[wom_pkg::PSEL_HI_POS:0]),
      .count_ff(count),
      .ovf_ff(ovf)
   );

   initial begin
      if (wom_pkg::STOP_GAP_CYC >= (1 << wom_pkg::GAP_W)) begin
         $error("stop gap counter too narrow");
      end
      if (wom_pkg::STOP_GAP_CYC < GAP_MIN ||
          wom_pkg::STOP_GAP_CYC > GAP_MAX) begin
         $error("stop gap outside its allowed range");
      end
   end
endmodule : wom_top

// [bench/wom_top_assertions.sv]
// concurrent checks on the watchdog block ports
`timescale 1ns/1ps
module wom_top_assertions (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [wom_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata_ff,
   input wire logic pready_ff,
   input wire logic pslverr_ff,
   // strap and reset request
   input wire logic osc_fixed_strap,
   input wire logic wdt_reset_ff
);
   logic done, mode_wr, key_wr, seen_ff, ex_ff;
   assign done = psel && penable && pready_ff;
   assign mode_wr = done && pwrite && paddr == wom_pkg::MODE_ADDR && pstrb[0];
   assign key_wr = done && pwrite && paddr == wom_pkg::KEY_ADDR;
   // first mode write and its stop exemption
   always_ff @(posedge clk) begin
      if (rst) begin
         seen_ff <= 1'b0;
         ex_ff <= 1'b0;
      end else if (mode_wr && !seen_ff) begin
         seen_ff <= 1'b1;
         ex_ff <= pwdata[4] && !osc_fixed_strap;
      end
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_ready_pulse: assert property (pready_ff |=> !pready_ff)
      else $error("ready held too long");
   a_ready_wait: assert property (psel && penable && !pready_ff |=> pready_ff)
      else $error("ready late");
   a_ready_cause: assert property ($rose(pready_ff) |-> $past(psel && penable))
      else $error("ready without access");
   a_rdata_idle: assert property (!pready_ff |-> prdata_ff == 32'h0000_0000)
      else $error("read data not idle");
   a_err_ready: assert property (pslverr_ff |-> pready_ff)
      else $error("error without ready");
   a_key_read: assert property (
      done && !pwrite && paddr == wom_pkg::KEY_ADDR
      |-> prdata_ff == {24'h00_0000, wom_pkg::KEY_READ})
      else $error("key read value");
   a_second_mode: assert property (
      mode_wr && seen_ff && !ex_ff |=> wdt_reset_ff)
      else $error("second mode write no reset");
   a_bad_key: assert property (
      key_wr && !ex_ff && (!pstrb[0] ||
      pwdata[7:0] != wom_pkg::KEY_RESTART) |=> wdt_reset_ff)
      else $error("bad key no reset");
   a_exempt_quiet: assert property (
      (mode_wr || key_wr) && ex_ff |=> !wdt_reset_ff)
      else $error("reset while exempt");
endmodule : wom_top_assertions

bind wom_top wom_top_assertions i_chk (.clk(clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
   .pslverr_ff(pslverr_ff), .osc_fixed_strap(osc_fixed_strap),
   .wdt_reset_ff(wdt_reset_ff));

// [bench/wom_top_test.sv]
// self-checking bench for the watchdog operation-mode block
`timescale 1ns/1ps
module wom_top_test;
   logic clk, rst, psel, penable, pwrite, slow_osc_clk, sys_osc_clk;
   logic osc_settled, osc_fixed_strap, halt_mode, stop_mode;
   logic crystal_in_use, pready_ff, pslverr_ff, wdt_reset_ff, err;
   logic [wom_pkg::ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata_ff, rd;
   logic [3:0] pstrb;
   int miscompares, n_tests, cyc, rs;
   localparam logic [17:0] M = wom_pkg::MODE_ADDR;
   localparam logic [17:0] K = wom_pkg::KEY_ADDR;
   localparam logic [17:0] S = wom_pkg::STAT_ADDR;

   wom_top i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
      .slow_osc_clk(slow_osc_clk), .sys_osc_clk(sys_osc_clk),
      .osc_settled(osc_settled), .osc_fixed_strap(osc_fixed_strap),
      .halt_mode(halt_mode), .stop_mode(stop_mode),
      .crystal_in_use(crystal_in_use), .wdt_reset_ff(wdt_reset_ff));

   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // reset pulse counter and run limit
   always @(posedge clk) begin
      cyc++;
      if (wdt_reset_ff === 1'b1) rs++;
      if (cyc > 60000) begin
         miscompares++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [17:0] a,
      input logic [31:0] d, input logic [3:0] s);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge clk) penable <= 1;
      do @(posedge clk); while (pready_ff !== 1'b1);
      rd = prdata_ff;
      err = pslverr_ff;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [17:0] a, input logic [7:0] d);
      apb(1, a, {24'h00_0000, d}, 4'h1);
      repeat (3) @(posedge clk);
   endtask : wr
   task automatic cnt(input int exp);
      apb(0, S, 32'h0000_0000, 4'h0);
      chk({11'h000, rd[20:0]}, exp);
   endtask : cnt
   task automatic tick(input int n);
      repeat (n) begin
         slow_osc_clk <= 1;
         repeat (2) @(posedge clk);
         slow_osc_clk <= 0;
         repeat (2) @(posedge clk);
      end
   endtask : tick
   task automatic stick(input int n);
      repeat (n) begin
         sys_osc_clk <= 1;
         repeat (2) @(posedge clk);
         sys_osc_clk <= 0;
         repeat (2) @(posedge clk);
      end
   endtask : stick
   task automatic do_rst(input logic strap);
      osc_fixed_strap <= strap;
      @(posedge clk) rst <= 1;
      repeat (3) @(posedge clk);
      rst <= 0;
      @(posedge clk);
   endtask : do_rst
   task automatic print_verdict();
      $display("compares %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////
   task automatic s_period();
      do_rst(0);
      apb(0, M, 0, 0);
      chk(rd, 32'h0000_0067);
      apb(0, K, 0, 0);
      chk(rd, 32'h0000_009A);
      apb(0, 18'h0_0010, 0, 0);
      chk({31'h0, err}, 1);
      tick(3);
      cnt(3);
      wr(M, 8'h60);
      cnt(0);
      tick(2000);
      wr(K, 8'hAC);
      cnt(0);
      tick(2047);
      chk(rs, 0);
      tick(1);
      repeat (4) @(posedge clk);
      chk(rs, 1);
   endtask : s_period
   task automatic s_faults();
      do_rst(0);
      rs = 0;
      wr(M, 8'h61);
      wr(M, 8'h61);
      chk(rs, 1);
      wr(K, 8'h12);
      chk(rs, 2);
      apb(1, K, 32'h0000_00AC, 4'h0);
      repeat (3) @(posedge clk);
      chk(rs, 3);
      do_rst(0);
      rs = 0;
      wr(M, 8'h70);
      wr(M, 8'h67);
      wr(K, 8'h00);
      apb(1, K, 32'h0000_00AC, 4'h0);
      repeat (3) @(posedge clk);
      chk(rs, 0);
      tick(10);
      cnt(0);
   endtask : s_faults
   task automatic s_halt();
      do_rst(0);
      wr(M, 8'h60);
      tick(7);
      halt_mode <= 1;
      tick(5);
      cnt(7);
      halt_mode <= 0;
      tick(2);
      cnt(9);
      stop_mode <= 1;
      tick(3);
      stop_mode <= 0;
      apb(0, S, 0, 0);
      chk({28'h000_0000, rd[27:24]}, 8);
      repeat (3230) @(posedge clk);
      tick(1);
      cnt(9);
      repeat (200) @(posedge clk);
      tick(1);
      cnt(10);
   endtask : s_halt
   task automatic s_sys();
      do_rst(0);
      wr(M, 8'h68);
      stick(5);
      tick(3);
      cnt(5);
      crystal_in_use <= 1;
      osc_settled <= 0;
      stop_mode <= 1;
      stick(2);
      stop_mode <= 0;
      apb(0, S, 0, 0);
      chk({28'h000_0000, rd[27:24]}, 4);
      osc_settled <= 1;
      repeat (4) @(posedge clk);
      apb(0, S, 0, 0);
      chk({28'h000_0000, rd[27:24]}, 8);
      chk({11'h000, rd[20:0]}, 5);
      crystal_in_use <= 0;
   endtask : s_sys
   task automatic s_fixed();
      do_rst(1);
      rs = 0;
      wr(M, 8'h78);
      apb(0, M, 0, 0);
      chk(rd, 32'h0000_0060);
      osc_fixed_strap <= 0;
      tick(4);
      cnt(4);
      chk({31'h0, rd[28]}, 1);
      halt_mode <= 1;
      stop_mode <= 1;
      tick(3);
      cnt(7);
      wr(K, 8'hAC);
      cnt(0);
      halt_mode <= 0;
      stop_mode <= 0;
      tick(2047);
      chk(rs, 0);
      tick(1);
      repeat (4) @(posedge clk);
      chk(rs, 1);
   endtask : s_fixed
   ////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0;
      pwdata = '0; pstrb = '0; slow_osc_clk = 0; sys_osc_clk = 0;
      osc_settled = 1; osc_fixed_strap = 0; halt_mode = 0;
      stop_mode = 0; crystal_in_use = 0;
      miscompares = 0; n_tests = 0; cyc = 0; rs = 0;
      repeat (3) @(posedge clk);
      s_period();
      s_faults();
      s_halt();
      s_sys();
      s_fixed();
      print_verdict();
   end
endmodule : wom_top_test
